// ===== rtl/scp_consts.vh
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCP_ADDR_CTRL        8'h00
`define SCP_ADDR_DIR         8'h04
`define SCP_ADDR_FUNC        8'h08
`define SCP_ADDR_GPIO_DIR    8'h0C
`define SCP_ADDR_GPIO_OUT    8'h10
`define SCP_ADDR_GPIO_IN     8'h14
`define SCP_ADDR_STATUS      8'h18

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SCP_CTRL_SHARED      0
`define SCP_CTRL_EXTBUF      1
`define SCP_CTRL_NETWORK     2
`define SCP_CTRL_OFLAG_LSB   4

// ----------------------------------------------------------------
// Direction register fields
// ----------------------------------------------------------------
`define SCP_DIR_RX_CLK       0
`define SCP_DIR_RX_FS        1
`define SCP_DIR_RX_HF        2
`define SCP_DIR_TX_CLK       3
`define SCP_DIR_TX_FS        4
`define SCP_DIR_TX_HF        5

// ----------------------------------------------------------------
// Pin indices
// ----------------------------------------------------------------
`define SCP_PIN_RX_CLK       0
`define SCP_PIN_RX_FS        1
`define SCP_PIN_RX_HF        2
`define SCP_PIN_TX_CLK       3
`define SCP_PIN_TX_FS        4
`define SCP_PIN_TX_HF        5

// ----------------------------------------------------------------
// Status register fields and clock source codes
// ----------------------------------------------------------------
`define SCP_STAT_IFLAG_LSB   0
`define SCP_STAT_RX_SRC_LSB  4
`define SCP_STAT_TX_SRC_LSB  6
`define SCP_SRC_BIT_PIN      2'h0
`define SCP_SRC_HF_PIN       2'h1
`define SCP_SRC_INTERNAL     2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCP_CTRL_RST         7'h00
`define SCP_DIR_RST          6'h00
`define SCP_FUNC_RST         6'h00
`define SCP_GPIO_DIR_RST     6'h00
`define SCP_GPIO_OUT_RST     6'h00

`endif

// ===== rtl/scp_sync.v
`timescale 1ns/1ps
`default_nettype none

module scp_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // scp_sync

`default_nettype wire

// ===== rtl/scp_pins.v
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.vh"

// How it works
// - Async mode: rx bit-clock pin clocks receivers, direction from rx clock bit.
// - Shared mode: rx bit-clock pin is flag 0; output follows flag-0 at frame sync.
// - Flag 0 input is captured at frame sync, or at slot in network mode.
// - Rx clock: internal if both bits set, hf pin if only clock bit, else pin.
// - Tx bit-clock pin clocks transmitters, direction from tx clock bit.
// - Shared mode: receivers use the transmit bit clock.
// - Async mode: rx frame-sync pin carries receiver frame sync, own direction bit.
// - Shared mode: rx frame-sync pin is flag 1, or buffer enable out.
// - Flag 1 drives and captures like flag 0.
// - Tx frame-sync pin serves transmitters, and receivers in shared mode.
// - Tx frame-sync output is internal sync; input used as frame sync.
// - Tx hf-clock pin feeds transmitters, and receivers in shared mode.
// - Tx hf-clock input replaces core clock; output gives usable clock.
// - Async mode: rx hf-clock pin feeds receivers, own direction bit.
// - Shared mode: rx hf-clock pin is flag 2, like flag 0.
// - Each pin falls back to general-purpose I/O when serial function unused.
// - Tx frame-sync pin input when its direction bit clear, output when set.
// - Tx clock bit set drives internal clock out; clear lets pin drive in.
module scp_pins (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  input  wire        INT_RX_BCLK,
  input  wire        INT_RX_FS,
  input  wire        INT_RX_HF,
  input  wire        INT_TX_BCLK,
  input  wire        INT_TX_FS,
  input  wire        INT_TX_HF,
  input  wire        TX_BUF_EN,
  input  wire        SLOT_STROBE,
  input  wire [5:0]  PIN_I,
  output reg  [5:0]  PIN_O,
  output reg  [5:0]  PIN_OE,
  output reg         RX_BCLK,
  output reg         TX_BCLK,
  output reg         RX_FS,
  output reg         TX_FS,
  output reg         RX_HF,
  output reg         TX_HF,
  output reg         TX_HF_EXT,
  output reg  [2:0]  IN_FLAGS
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [1:0] clk_src;
    input hf_dir;
    input clk_dir;
    begin
      if (hf_dir && clk_dir) begin
        clk_src = `SCP_SRC_INTERNAL;
      end else if (clk_dir) begin
        clk_src = `SCP_SRC_HF_PIN;
      end else begin
        clk_src = `SCP_SRC_BIT_PIN;
      end
    end
  endfunction

  function clk_pick;
    input [1:0] src;
    input       int_clk;
    input       hf_pin;
    input       bit_pin;
    begin
      if (src == `SCP_SRC_INTERNAL) begin
        clk_pick = int_clk;
      end else if (src == `SCP_SRC_HF_PIN) begin
        clk_pick = hf_pin;
      end else begin
        clk_pick = bit_pin;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [6:0] ctrl_reg;
  reg  [5:0] dir_reg;
  reg  [5:0] func_reg;
  reg  [5:0] gpio_dir_reg;
  reg  [5:0] gpio_out_reg;
  reg  [2:0] oflag_reg;
  reg  [2:0] iflag_reg;
  reg        fs_del_reg;

  wire [5:0] pin_s;

  wire       shared_clock_mode        = ctrl_reg[`SCP_CTRL_SHARED];
  wire       ext_buffer_enable_select = ctrl_reg[`SCP_CTRL_EXTBUF];
  wire       network_mode             = ctrl_reg[`SCP_CTRL_NETWORK];
  wire [2:0] out_flag_ctl             = ctrl_reg[`SCP_CTRL_OFLAG_LSB+2:`SCP_CTRL_OFLAG_LSB];

  wire       rx_clock_direction       = dir_reg[`SCP_DIR_RX_CLK];
  wire       rx_frame_sync_direction  = dir_reg[`SCP_DIR_RX_FS];
  wire       rx_hf_clock_direction    = dir_reg[`SCP_DIR_RX_HF];
  wire       tx_clock_direction       = dir_reg[`SCP_DIR_TX_CLK];
  wire       tx_frame_sync_direction  = dir_reg[`SCP_DIR_TX_FS];
  wire       tx_hf_clock_direction    = dir_reg[`SCP_DIR_TX_HF];

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Pins are sampled by core clock only; slow enough external clocks assumed
  scp_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   (PIN_I),
    .q   (pin_s)
  );

  // ----------------------------------------------------------------
  // Clock and frame sync selection
  // ----------------------------------------------------------------
  wire [1:0] rx_src_async = clk_src(rx_hf_clock_direction, rx_clock_direction);
  wire [1:0] tx_src       = clk_src(tx_hf_clock_direction, tx_clock_direction);

  wire tx_bclk_sel = clk_pick(tx_src, INT_TX_BCLK, pin_s[`SCP_PIN_TX_HF],
                              pin_s[`SCP_PIN_TX_CLK]);
  wire rx_bclk_async = clk_pick(rx_src_async, INT_RX_BCLK, pin_s[`SCP_PIN_RX_HF],
                                pin_s[`SCP_PIN_RX_CLK]);
  wire rx_bclk_sel = shared_clock_mode ? tx_bclk_sel : rx_bclk_async;
  wire [1:0] rx_src = shared_clock_mode ? tx_src : rx_src_async;

  // Output direction uses internal sync, input uses pin
  wire tx_fs_sel = tx_frame_sync_direction ? INT_TX_FS
                                           : pin_s[`SCP_PIN_TX_FS];
  wire rx_fs_async = rx_frame_sync_direction ? INT_RX_FS
                                             : pin_s[`SCP_PIN_RX_FS];
  wire rx_fs_sel = shared_clock_mode ? tx_fs_sel : rx_fs_async;

  // Input pin replaces the core-derived high frequency clock
  wire tx_hf_sel = tx_hf_clock_direction ? INT_TX_HF
                                         : pin_s[`SCP_PIN_TX_HF];
  wire rx_hf_async = rx_hf_clock_direction ? INT_RX_HF
                                           : pin_s[`SCP_PIN_RX_HF];
  wire rx_hf_sel = shared_clock_mode ? tx_hf_sel : rx_hf_async;

  // ----------------------------------------------------------------
  // Serial flags
  // ----------------------------------------------------------------
  // Flag 1 exists only while buffer enable is not selected
  wire [2:0] flag_mode;
  wire [2:0] flag_dir;

  assign flag_mode[0] = shared_clock_mode & func_reg[`SCP_PIN_RX_CLK];
  assign flag_mode[1] = shared_clock_mode & ~ext_buffer_enable_select
                        & func_reg[`SCP_PIN_RX_FS];
  assign flag_mode[2] = shared_clock_mode & func_reg[`SCP_PIN_RX_HF];
  assign flag_dir     = {rx_hf_clock_direction, rx_frame_sync_direction,
                         rx_clock_direction};

  wire fs_rise   = tx_fs_sel & ~fs_del_reg;
  wire flag_tick = network_mode ? SLOT_STROBE : fs_rise;
  wire [2:0] flag_pin = {pin_s[`SCP_PIN_RX_HF], pin_s[`SCP_PIN_RX_FS],
                         pin_s[`SCP_PIN_RX_CLK]};

  always @(posedge REF_CLK) begin
    if (RST) begin
      fs_del_reg <= 1'b0;
    end else begin
      fs_del_reg <= tx_fs_sel;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_flag
      // Output flag changes only on frame sync so the peer sees it aligned
      always @(posedge REF_CLK) begin
        if (RST) begin
          oflag_reg[g] <= 1'b0;
        end else if (fs_rise) begin
          oflag_reg[g] <= out_flag_ctl[g];
        end
      end

      // Input flag sampled at frame sync or time slot
      always @(posedge REF_CLK) begin
        if (RST) begin
          iflag_reg[g] <= 1'b0;
        end else if (flag_mode[g] && !flag_dir[g] && flag_tick) begin
          iflag_reg[g] <= flag_pin[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  reg [5:0] pin_o_next;
  reg [5:0] pin_oe_next;
  reg [5:0] ser_o;
  reg [5:0] ser_oe;

  always @* begin
    ser_o  = 6'h00;
    ser_oe = 6'h00;
    // Receive bit clock pin
    if (shared_clock_mode) begin
      ser_oe[`SCP_PIN_RX_CLK] = rx_clock_direction;
      ser_o[`SCP_PIN_RX_CLK]  = oflag_reg[0];
    end else begin
      ser_oe[`SCP_PIN_RX_CLK] = rx_clock_direction;
      ser_o[`SCP_PIN_RX_CLK]  = INT_RX_BCLK;
    end
    // Receive frame sync pin
    if (!shared_clock_mode) begin
      ser_oe[`SCP_PIN_RX_FS] = rx_frame_sync_direction;
      ser_o[`SCP_PIN_RX_FS]  = INT_RX_FS;
    end else if (!ext_buffer_enable_select) begin
      ser_oe[`SCP_PIN_RX_FS] = rx_frame_sync_direction;
      ser_o[`SCP_PIN_RX_FS]  = oflag_reg[1];
    end else begin
      ser_oe[`SCP_PIN_RX_FS] = rx_frame_sync_direction;
      ser_o[`SCP_PIN_RX_FS]  = TX_BUF_EN;
    end
    // Receive high frequency clock pin
    if (shared_clock_mode) begin
      ser_oe[`SCP_PIN_RX_HF] = rx_hf_clock_direction;
      ser_o[`SCP_PIN_RX_HF]  = oflag_reg[2];
    end else begin
      ser_oe[`SCP_PIN_RX_HF] = rx_hf_clock_direction;
      ser_o[`SCP_PIN_RX_HF]  = INT_RX_HF;
    end
    // Transmit pins
    ser_oe[`SCP_PIN_TX_CLK] = tx_clock_direction;
    ser_o[`SCP_PIN_TX_CLK]  = INT_TX_BCLK;
    ser_oe[`SCP_PIN_TX_FS]  = tx_frame_sync_direction;
    ser_o[`SCP_PIN_TX_FS]   = INT_TX_FS;
    ser_oe[`SCP_PIN_TX_HF]  = tx_hf_clock_direction;
    ser_o[`SCP_PIN_TX_HF]   = INT_TX_HF;
  end

  always @* begin
    pin_o_next  = (func_reg & ser_o) | (~func_reg & gpio_out_reg);
    pin_oe_next = (func_reg & ser_oe) | (~func_reg & gpio_dir_reg);
  end

  // Registered pin drive adds one cycle but keeps outputs glitch free
  always @(posedge REF_CLK) begin
    if (RST) begin
      PIN_O  <= 6'h00;
      PIN_OE <= 6'h00;
    end else begin
      PIN_O  <= pin_o_next;
      PIN_OE <= pin_oe_next;
    end
  end

  // ----------------------------------------------------------------
  // Selected clocks to the shifters
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (RST) begin
      RX_BCLK   <= 1'b0;
      TX_BCLK   <= 1'b0;
      RX_FS     <= 1'b0;
      TX_FS     <= 1'b0;
      RX_HF     <= 1'b0;
      TX_HF     <= 1'b0;
      TX_HF_EXT <= 1'b0;
      IN_FLAGS  <= 3'h0;
    end else begin
      RX_BCLK   <= rx_bclk_sel;
      TX_BCLK   <= tx_bclk_sel;
      RX_FS     <= rx_fs_sel;
      TX_FS     <= tx_fs_sel;
      RX_HF     <= rx_hf_sel;
      TX_HF     <= tx_hf_sel;
      TX_HF_EXT <= ~tx_hf_clock_direction;
      IN_FLAGS  <= iflag_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_reg     <= `SCP_CTRL_RST;
      dir_reg      <= `SCP_DIR_RST;
      func_reg     <= `SCP_FUNC_RST;
      gpio_dir_reg <= `SCP_GPIO_DIR_RST;
      gpio_out_reg <= `SCP_GPIO_OUT_RST;
    end else if (WR) begin
      if (ADDR == `SCP_ADDR_CTRL) begin
        ctrl_reg <= WDATA[6:0];
      end else if (ADDR == `SCP_ADDR_DIR) begin
        dir_reg <= WDATA[5:0];
      end else if (ADDR == `SCP_ADDR_FUNC) begin
        func_reg <= WDATA[5:0];
      end else if (ADDR == `SCP_ADDR_GPIO_DIR) begin
        gpio_dir_reg <= WDATA[5:0];
      end else if (ADDR == `SCP_ADDR_GPIO_OUT) begin
        gpio_out_reg <= WDATA[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h0000_0000;
    if (ADDR == `SCP_ADDR_CTRL) begin
      rdata_next[6:0] = ctrl_reg;
    end else if (ADDR == `SCP_ADDR_DIR) begin
      rdata_next[5:0] = dir_reg;
    end else if (ADDR == `SCP_ADDR_FUNC) begin
      rdata_next[5:0] = func_reg;
    end else if (ADDR == `SCP_ADDR_GPIO_DIR) begin
      rdata_next[5:0] = gpio_dir_reg;
    end else if (ADDR == `SCP_ADDR_GPIO_OUT) begin
      rdata_next[5:0] = gpio_out_reg;
    end else if (ADDR == `SCP_ADDR_GPIO_IN) begin
      rdata_next[5:0] = pin_s;
    end else if (ADDR == `SCP_ADDR_STATUS) begin
      rdata_next[`SCP_STAT_IFLAG_LSB+2:`SCP_STAT_IFLAG_LSB]   = iflag_reg;
      rdata_next[`SCP_STAT_RX_SRC_LSB+1:`SCP_STAT_RX_SRC_LSB] = rx_src;
      rdata_next[`SCP_STAT_TX_SRC_LSB+1:`SCP_STAT_TX_SRC_LSB] = tx_src;
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule // scp_pins

`default_nettype wire

// ===== verif/scp_pins_props.sv
`timescale 1ns/1ps
`default_nettype none
module scp_pins_props (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        INT_RX_BCLK,
  input wire logic        INT_RX_HF,
  input wire logic        INT_TX_BCLK,
  input wire logic        INT_TX_FS,
  input wire logic        INT_TX_HF,
  input wire logic [5:0]  PIN_O,
  input wire logic [5:0]  PIN_OE,
  input wire logic        RX_BCLK,
  input wire logic        TX_BCLK,
  input wire logic        RX_FS,
  input wire logic        TX_FS,
  input wire logic        RX_HF,
  input wire logic        TX_HF
);
  // ------
  // Shadow setup, same timing as the real registers
  // ------
  logic [5:0] dir_reg, fn_reg, gd_reg, go_reg;
  logic       shr_reg;
  always @(posedge REF_CLK) begin
    if (RST) begin
      {dir_reg, fn_reg, gd_reg, go_reg, shr_reg} <= 25'h0000000;
    end else if (WR) begin
      case (ADDR)
        8'h00: shr_reg <= WDATA[0];
        8'h04: dir_reg <= WDATA[5:0];
        8'h08: fn_reg <= WDATA[5:0];
        8'h0C: gd_reg <= WDATA[5:0];
        8'h10: go_reg <= WDATA[5:0];
        default: ;
      endcase
    end
  end
  function automatic logic [1:0] src_f(input logic h, input logic c);
    return (h && c) ? 2'h2 : {1'b0, c};
  endfunction
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ------
  // Checks
  // ------
  a_tx_pin_dir: assert property (PIN_OE[5:3] == $past((fn_reg[5:3] & dir_reg[5:3]) |
    (~fn_reg[5:3] & gd_reg[5:3]))) else $error("tx pin enable wrong");
  a_gpio_dir: assert property (($past(~fn_reg) & (PIN_OE ^ $past(gd_reg))) == 6'h00)
    else $error("gpio enable wrong");
  a_gpio_drive: assert property (($past(~fn_reg & gd_reg) & (PIN_O ^ $past(go_reg))) == 6'h00)
    else $error("gpio drive wrong");
  a_tx_bclk_out: assert property ($past(fn_reg[3] & dir_reg[3]) |-> PIN_O[3] == $past(INT_TX_BCLK))
    else $error("tx bit clock out wrong");
  a_tx_hf_out: assert property ($past(fn_reg[5] & dir_reg[5]) |-> PIN_O[5] == $past(INT_TX_HF))
    else $error("tx hf clock out wrong");
  a_rx_bclk_out: assert property ($past(!shr_reg & fn_reg[0] & dir_reg[0]) |-> PIN_O[0] == $past(INT_RX_BCLK))
    else $error("rx bit clock out wrong");
  a_rx_hf_out: assert property ($past(!shr_reg & fn_reg[2] & dir_reg[2]) |-> PIN_O[2] == $past(INT_RX_HF))
    else $error("rx hf clock out wrong");
  a_rx_int_sel: assert property ($past(!shr_reg & dir_reg[2] & dir_reg[0]) |-> RX_BCLK == $past(INT_RX_BCLK))
    else $error("rx bit clock select wrong");
  a_tx_fs_sel: assert property ($past(dir_reg[4]) |-> TX_FS == $past(INT_TX_FS))
    else $error("tx frame sync wrong");
  a_tx_int_sel: assert property ($past(dir_reg[5] & dir_reg[3]) |-> TX_BCLK == $past(INT_TX_BCLK))
    else $error("tx bit clock select wrong");
  a_shared_clk: assert property ($past(shr_reg) |-> {RX_BCLK, RX_FS, RX_HF} ==
    {TX_BCLK, TX_FS, TX_HF}) else $error("shared clocks differ");
  a_src_status: assert property ($past(RD && ADDR == 8'h18 && !shr_reg) |-> RDATA[7:4] ==
    $past({src_f(dir_reg[5], dir_reg[3]), src_f(dir_reg[2], dir_reg[0])}))
    else $error("clock source status wrong");
  a_rd_idle: assert property (!$past(RD) |-> RDATA == 32'h00000000)
    else $error("read data outside answer");
endmodule // scp_pins_props
bind scp_pins scp_pins_props chk_u (
  .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .INT_RX_BCLK(INT_RX_BCLK), .INT_RX_HF(INT_RX_HF),
  .INT_TX_BCLK(INT_TX_BCLK), .INT_TX_FS(INT_TX_FS), .INT_TX_HF(INT_TX_HF),
  .PIN_O(PIN_O), .PIN_OE(PIN_OE), .RX_BCLK(RX_BCLK), .TX_BCLK(TX_BCLK), .RX_FS(RX_FS),
  .TX_FS(TX_FS), .RX_HF(RX_HF), .TX_HF(TX_HF)
);
`default_nettype wire

// ===== verif/scp_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module scp_far_end (
  input  wire logic       run,
  input  wire logic       shared,
  input  wire logic [2:0] flags,
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe,
  output logic      [5:0] pin_i
);
  logic       bclk = 1'b0;
  logic       hf = 1'b0;
  logic       fs;
  logic [2:0] beat = 3'h0;
  // Clocks stand low while run is clear; phases stay above 1.5 core cycles
  always #16 bclk <= run & ~bclk;
  always #8 hf <= run & ~hf;
  always @(posedge bclk) beat <= beat + 3'h1;
  assign fs = run && beat == 3'h0;
  // Device wins on any pin it drives
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & {hf, fs, bclk, shared ? flags : {hf, fs, bclk}});
endmodule // scp_far_end
`default_nettype wire

// ===== verif/scp_pins_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module scp_pins_tb_top;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic        ben = 1'b0, slot = 1'b0, run = 1'b0, shr = 1'b0;
  logic [2:0]  flg = 3'h0;
  logic [7:0]  addr = 8'h00, cnt = 8'h00;
  logic [31:0] wdata = 32'h00000000, seed = 32'hACE302B9;
  wire  [31:0] rdata;
  wire  [5:0]  pin_i, pin_o, pin_oe;
  wire  [2:0]  in_flags;
  wire         hfx;
  logic [31:0] expq[$];
  int          failures = 0, checks_done = 0, cycles = 0;
  always #2 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 8'h01;
  scp_pins dut_u (
    .REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .INT_RX_BCLK(cnt[2]), .INT_RX_FS(cnt[5:0] == 6'h00),
    .INT_RX_HF(cnt[0]), .INT_TX_BCLK(cnt[1]), .INT_TX_FS(cnt[4:0] == 5'h00),
    .INT_TX_HF(cnt[0]), .TX_BUF_EN(ben), .SLOT_STROBE(slot), .PIN_I(pin_i),
    .PIN_O(pin_o), .PIN_OE(pin_oe), .RX_BCLK(), .TX_BCLK(), .RX_FS(), .TX_FS(),
    .RX_HF(), .TX_HF(), .TX_HF_EXT(hfx), .IN_FLAGS(in_flags)
  );
  scp_far_end far_u (
    .run(run), .shared(shr), .flags(flg), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i)
  );
  // ------
  // Helpers
  // ------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] src(input logic [2:0] v);
    return (v[2] && v[0]) ? 2'h2 : {1'b0, v[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    expq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Answer stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    cycles++;
    if (rd_q) check(rdata, expq.pop_front(), "read data");
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end
  // ------
  // Scenarios
  // ------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_reg(8'(a * 4), 32'h00000000);
    wr_reg(8'hFF, seed);
    wr_reg(8'h18, seed);
    wr_reg(8'h14, seed);
    rd_reg(8'hFF, 32'h00000000);
    rd_reg(8'h18, 32'h00000000);
    rd_reg(8'h14, 32'h00000000);
    for (int a = 0; a < 5; a++) begin
      seed = xs(seed);
      wr_reg(8'(a * 4), seed);
      rd_reg(8'(a * 4), seed & (a == 0 ? 32'h7F : 32'h3F));
    end
    $display("test registers done");
    wr_reg(8'h00, 32'h00000000);
    wr_reg(8'h08, 32'h0000003F);
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h04, {26'h0, 3'(i), 3'(i)});
      rd_reg(8'h18, {24'h0, {2{src(3'(i))}}, 4'h0});
      check(hfx, {31'h0, !i[2]}, "hf from pin");
    end
    $display("test clock sources done");
    seed = xs(seed);
    shr <= 1'b1;
    flg <= 3'b110;
    wr_reg(8'h08, 32'h00000000);
    wr_reg(8'h0C, seed);
    wr_reg(8'h10, seed >> 8);
    repeat (4) @(posedge clk);
    check(pin_oe, seed[5:0], "pin enable");
    check(pin_o & seed[5:0], seed[13:8] & seed[5:0], "pin drive");
    rd_reg(8'h14, 6'((seed[5:0] & seed[13:8]) | (~seed[5:0] & 6'h06)));
    $display("test gpio done");
    wr_reg(8'h08, 32'h0000003F);
    wr_reg(8'h04, 32'h00000000);
    wr_reg(8'h00, 32'h00000001);
    flg <= 3'b101;
    run <= 1'b1;
    repeat (200) @(posedge clk);
    check(in_flags, 3'b101, "input flags");
    rd_reg(8'h18, 32'h00000005);
    flg <= 3'b010;
    repeat (200) @(posedge clk);
    rd_reg(8'h18, 32'h00000002);
    run <= 1'b0;
    $display("test flag capture done");
    wr_reg(8'h04, 32'h00000015);
    wr_reg(8'h00, 32'h00000051);
    repeat (80) @(posedge clk);
    check(pin_oe, 6'h15, "pin enable");
    check(pin_o & 6'h05, 6'h05, "out flags");
    wr_reg(8'h04, 32'h00000017);
    wr_reg(8'h00, 32'h00000003);
    ben <= 1'b1;
    repeat (80) @(posedge clk);
    check(pin_o & 6'h07, 6'h02, "buffer enable");
    ben <= 1'b0;
    repeat (4) @(posedge clk);
    check(pin_o[1], 1'b0, "buffer enable");
    $display("test out flags done");
    wr_reg(8'h04, 32'h00000010);
    wr_reg(8'h00, 32'h00000005);
    flg <= 3'b111;
    repeat (80) @(posedge clk);
    rd_reg(8'h18, 32'h00000002);
    slot <= 1'b1;
    @(posedge clk);
    slot <= 1'b0;
    repeat (6) @(posedge clk);
    rd_reg(8'h18, 32'h00000007);
    repeat (2) @(posedge clk);
    $display("test network slot done");
    give_verdict();
  end
endmodule // scp_pins_tb_top
`default_nettype wire
